// ===== hw/lpt_timing_top.sv
// LCD panel timing output: frame and line syncs, bias or data enable,
// pixel clock and 16-bit pixel data, for passive or active-matrix panels.
// Assumes pixels arrive as a valid/ready stream on ref_clk and that the
// mode select and enable are driven by logic on ref_clk.
//
// Summary of operation
// - frame sync marks the start of every new frame sent to the panel.
// - in active-matrix mode the frame sync is the vertical sync.
// - line sync marks the end of each line of pixels sent.
// - in active-matrix mode the line sync is the horizontal sync.
// - passive mode toggles bias to reverse panel supply polarity.
// - active-matrix mode uses bias as data enable for latching pixels.
// - a pixel clock is output; pixel data is synchronous to it.
// - passive mode: pixel clock toggles only while pixel data is valid.
// - active-matrix: pixel clock runs continuously; enable marks valid data.
`timescale 1ns/1ps
module lpt_timing_top #(
	parameter int PIX_W = lpt_pkg::PIX_W_DEF,
	parameter int FIFO_DEPTH = lpt_pkg::FIFO_DEPTH_DEF,
	parameter int PCLK_HALF_CYC = lpt_pkg::PCLK_HALF_CYC_DEF,
	parameter int CNT_W = lpt_pkg::CNT_W_DEF,
	parameter int H_ACTIVE = lpt_pkg::H_ACTIVE_DEF,
	parameter int H_FP = lpt_pkg::H_FP_DEF,
	parameter int H_SYNC = lpt_pkg::H_SYNC_DEF,
	parameter int H_BP = lpt_pkg::H_BP_DEF,
	parameter int V_SYNC = lpt_pkg::V_SYNC_DEF,
	parameter int V_BP = lpt_pkg::V_BP_DEF,
	parameter int V_ACTIVE = lpt_pkg::V_ACTIVE_DEF,
	parameter int V_FP = lpt_pkg::V_FP_DEF,
	parameter int BIAS_FRAMES = lpt_pkg::BIAS_FRAMES_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Configuration
	input wire logic enable_in,
	input wire logic active_matrix_mode,
	// Pixel stream in
	input wire logic [PIX_W-1:0] pix_in_data,
	input wire logic pix_in_valid,
	output logic pix_in_ready,
	// Panel pins
	output logic frame_sync_out,
	output logic line_sync_out,
	output logic bias_or_data_enable_out,
	output logic pixel_clock_out,
	output logic [PIX_W-1:0] pixel_data_bus,
	// Status
	output logic mode_active_out,
	output logic frame_start_out,
	output logic underrun_out
);
	import lpt_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// Timing constants at counter width

	localparam logic [CNT_W-1:0] H_ACT_E = CNT_W'(H_ACTIVE);
	localparam logic [CNT_W-1:0] H_SYNC_S = CNT_W'(H_ACTIVE + H_FP);
	localparam logic [CNT_W-1:0] H_SYNC_E = CNT_W'(H_ACTIVE + H_FP + H_SYNC);
	localparam logic [CNT_W-1:0] H_LAST =
		CNT_W'(H_ACTIVE + H_FP + H_SYNC + H_BP - 1);
	localparam logic [CNT_W-1:0] V_SYNC_E = CNT_W'(V_SYNC);
	localparam logic [CNT_W-1:0] V_ACT_S = CNT_W'(V_SYNC + V_BP);
	localparam logic [CNT_W-1:0] V_ACT_E = CNT_W'(V_SYNC + V_BP + V_ACTIVE);
	localparam logic [CNT_W-1:0] V_LAST =
		CNT_W'(V_SYNC + V_BP + V_ACTIVE + V_FP - 1);
	localparam logic [7:0] BIAS_LAST = 8'(BIAS_FRAMES - 1);

	////////////////////////////////////////////////////////////////////////
	// Pixel stream buffer and pixel-clock divider

	logic fifo_valid;
	logic fifo_pop;
	logic [PIX_W-1:0] fifo_data;
	logic half_tick;
	lpt_state_e state_reg;
	lpt_state_e state_next;

	lpt_fifo #(
		.W(PIX_W),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.in_valid(pix_in_valid),
		.in_ready(pix_in_ready),
		.in_data(pix_in_data),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_data)
	);

	lpt_clk_div #(
		.DIV(PCLK_HALF_CYC),
		.CW(8)
	) u_div (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.run(state_reg == LPT_RUN),
		.tick(half_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Scan state

	logic [CNT_W-1:0] h_reg;
	logic [CNT_W-1:0] h_next;
	logic [CNT_W-1:0] v_reg;
	logic [CNT_W-1:0] v_next;
	logic phase_reg;
	logic phase_next;
	logic am_reg;
	logic am_next;
	logic [7:0] bias_cnt_reg;
	logic [7:0] bias_cnt_next;
	logic bias_tgl_reg;
	logic bias_tgl_next;
	logic valid_reg;
	logic valid_next;

	// Panel and status output registers
	logic vs_reg;
	logic vs_next;
	logic hs_reg;
	logic hs_next;
	logic ac_reg;
	logic ac_next;
	logic pclk_reg;
	logic pclk_next;
	logic [PIX_W-1:0] data_reg;
	logic [PIX_W-1:0] data_next;
	logic fstart_reg;
	logic fstart_next;
	logic urun_reg;
	logic urun_next;

	logic pix_tick;
	logic h_wrap;
	logic v_wrap;
	logic in_active;

	// Data moves on the falling pixel-clock phase, panel samples on rising
	assign pix_tick = half_tick && phase_reg;

	always_comb
	begin
		state_next = state_reg;
		h_next = h_reg;
		v_next = v_reg;
		phase_next = phase_reg;
		am_next = am_reg;
		bias_cnt_next = bias_cnt_reg;
		bias_tgl_next = bias_tgl_reg;
		valid_next = valid_reg;
		vs_next = vs_reg;
		hs_next = hs_reg;
		ac_next = ac_reg;
		pclk_next = pclk_reg;
		data_next = data_reg;
		fstart_next = 1'b0;
		urun_next = 1'b0;
		fifo_pop = 1'b0;
		h_wrap = (h_reg == H_LAST);
		v_wrap = h_wrap && (v_reg == V_LAST);
		in_active = 1'b0;

		case (state_reg)
			LPT_OFF:
			begin
				// Park just before a frame so the first tick starts one
				h_next = H_LAST;
				v_next = V_LAST;
				phase_next = 1'b0;
				valid_next = 1'b0;
				vs_next = SYNC_RST;
				hs_next = SYNC_RST;
				ac_next = BIAS_RST;
				pclk_next = PCLK_RST;
				data_next = '0;
				am_next = active_matrix_mode;
				if (enable_in)
				begin
					state_next = LPT_RUN;
				end
			end
			LPT_RUN:
			begin
				if (half_tick)
				begin
					phase_next = !phase_reg;
				end
				if (pix_tick)
				begin
					h_next = h_wrap ? '0 : h_reg + 1'b1;
					if (h_wrap)
					begin
						v_next = v_wrap ? '0 : v_reg + 1'b1;
					end
					if (v_wrap)
					begin
						// Mode changes only between frames
						am_next = active_matrix_mode;
						fstart_next = 1'b1;
						if (bias_cnt_reg == BIAS_LAST)
						begin
							bias_cnt_next = '0;
							bias_tgl_next = !bias_tgl_reg;
						end
						else
						begin
							bias_cnt_next = bias_cnt_reg + 1'b1;
						end
					end
					in_active = (h_next < H_ACT_E) &&
						(v_next >= V_ACT_S) && (v_next < V_ACT_E);
					valid_next = in_active;
					// Sync ahead of the frame's active lines
					vs_next = (v_next < V_SYNC_E);
					// Pulse after each line's active pixels
					hs_next = (h_next >= H_SYNC_S) &&
						(h_next < H_SYNC_E);
					if (in_active)
					begin
						fifo_pop = fifo_valid;
						data_next = fifo_valid ? fifo_data : '0;
						urun_next = !fifo_valid;
					end
					else
					begin
						data_next = '0;
					end
					// Both modes drawn from the same latched selection
					ac_next = am_next ? in_active : bias_tgl_next;
				end
				if (half_tick)
				begin
					// Passive gates the clock to valid data, active runs free
					pclk_next = phase_next &&
						(am_reg || valid_reg);
				end
				if (!enable_in && pix_tick && v_wrap)
				begin
					// Stop only at a frame boundary so the panel sees whole frames
					state_next = LPT_OFF;
				end
			end
			default:
			begin
				state_next = LPT_OFF;
			end
		endcase
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			state_reg <= LPT_OFF;
			h_reg <= '0;
			v_reg <= '0;
			phase_reg <= 1'b0;
			am_reg <= 1'b0;
			bias_cnt_reg <= '0;
			bias_tgl_reg <= BIAS_RST;
			valid_reg <= 1'b0;
			vs_reg <= SYNC_RST;
			hs_reg <= SYNC_RST;
			ac_reg <= BIAS_RST;
			pclk_reg <= PCLK_RST;
			data_reg <= '0;
			fstart_reg <= 1'b0;
			urun_reg <= 1'b0;
		end
		else
		begin
			state_reg <= state_next;
			h_reg <= h_next;
			v_reg <= v_next;
			phase_reg <= phase_next;
			am_reg <= am_next;
			bias_cnt_reg <= bias_cnt_next;
			bias_tgl_reg <= bias_tgl_next;
			valid_reg <= valid_next;
			vs_reg <= vs_next;
			hs_reg <= hs_next;
			ac_reg <= ac_next;
			pclk_reg <= pclk_next;
			data_reg <= data_next;
			fstart_reg <= fstart_next;
			urun_reg <= urun_next;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs

	assign frame_sync_out = vs_reg;
	assign line_sync_out = hs_reg;
	assign bias_or_data_enable_out = ac_reg;
	assign pixel_clock_out = pclk_reg;
	assign pixel_data_bus = data_reg;
	assign mode_active_out = am_reg;
	assign frame_start_out = fstart_reg;
	assign underrun_out = urun_reg;

endmodule : lpt_timing_top

// ===== hw/lpt_pkg.sv
// Shared constants for the LCD panel timing output block.
// Assumes a single 100 MHz reference clock; no software-visible registers.
package lpt_pkg;

	// Reference clock
	localparam int REF_CLK_MHZ = 100;
	localparam int REF_CLK_PERIOD_NS = 10;

	// Pixel clock: half period in reference cycles (40 ns -> 80 ns period)
	localparam int PCLK_HALF_NS = 40;
	localparam int PCLK_HALF_CYC_DEF =
		(PCLK_HALF_NS * REF_CLK_MHZ + 999) / 1000;

	// Pixel data and stream buffer
	localparam int PIX_W_DEF = 16;
	localparam int FIFO_DEPTH_DEF = 32;

	// Horizontal timing in pixel clocks: active, front porch, sync, back porch
	localparam int H_ACTIVE_DEF = 320;
	localparam int H_FP_DEF = 8;
	localparam int H_SYNC_DEF = 4;
	localparam int H_BP_DEF = 8;

	// Vertical timing in lines: sync, back porch, active, front porch
	localparam int V_SYNC_DEF = 1;
	localparam int V_BP_DEF = 2;
	localparam int V_ACTIVE_DEF = 240;
	localparam int V_FP_DEF = 2;

	// Frames between bias reversals in passive mode
	localparam int BIAS_FRAMES_DEF = 1;

	// Timing counter width
	localparam int CNT_W_DEF = 12;

	// Reset values of panel outputs
	localparam logic SYNC_RST = 1'b0;
	localparam logic BIAS_RST = 1'b0;
	localparam logic PCLK_RST = 1'b0;

	// Scan machine states
	typedef enum logic {LPT_OFF, LPT_RUN} lpt_state_e;

endpackage : lpt_pkg

// ===== hw/lpt_clk_div.sv
// Divider that makes the pixel-clock half-period enable pulse.
// Assumes run is a level on ref_clk; tick is one ref_clk cycle wide.
`timescale 1ns/1ps
module lpt_clk_div #(
	parameter int DIV = lpt_pkg::PCLK_HALF_CYC_DEF,
	parameter int CW = 8
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Control
	input wire logic run,
	// Enable pulse
	output logic tick
);
	import lpt_pkg::*;

	localparam logic [CW-1:0] LAST = CW'(DIV - 1);

	logic [CW-1:0] cnt_reg;
	logic [CW-1:0] cnt_next;
	logic tick_reg;
	logic tick_next;

	always_comb
	begin
		cnt_next = cnt_reg;
		tick_next = 1'b0;
		if (!run)
		begin
			cnt_next = '0;
		end
		else if (cnt_reg == LAST)
		begin
			cnt_next = '0;
			tick_next = 1'b1;
		end
		else
		begin
			cnt_next = cnt_reg + 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cnt_reg <= '0;
			tick_reg <= 1'b0;
		end
		else
		begin
			cnt_reg <= cnt_next;
			tick_reg <= tick_next;
		end
	end

	assign tick = tick_reg;

endmodule : lpt_clk_div

// ===== hw/lpt_fifo.sv
// Synchronous FIFO for the pixel stream, valid/ready on both sides.
// Assumes one clock; full and empty are exact, depth is a power of two.
`timescale 1ns/1ps
module lpt_fifo #(
	parameter int W = lpt_pkg::PIX_W_DEF,
	parameter int DEPTH = lpt_pkg::FIFO_DEPTH_DEF
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Filling side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// Draining side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	import lpt_pkg::*;

	localparam int AW = $clog2(DEPTH);

	logic [W-1:0] mem [DEPTH];
	logic [AW:0] wr_reg;
	logic [AW:0] wr_next;
	logic [AW:0] rd_reg;
	logic [AW:0] rd_next;
	logic full;
	logic empty;
	logic push;
	logic pop;

	assign full = (wr_reg[AW] != rd_reg[AW]) &&
		(wr_reg[AW-1:0] == rd_reg[AW-1:0]);
	assign empty = (wr_reg == rd_reg);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;
	// Read port comes straight off the storage flops
	assign out_data = mem[rd_reg[AW-1:0]];

	always_comb
	begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
	end

	always_ff @(posedge ref_clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			wr_reg <= '0;
			rd_reg <= '0;
		end
		else
		begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
		end
	end

	// Storage has no reset; nothing is read before it is written
	always_ff @(posedge ref_clk)
	begin
		if (push)
		begin
			mem[wr_reg[AW-1:0]] <= in_data;
		end
	end

endmodule : lpt_fifo

// ===== tb/lpt_timing_props.sv
// Checker for the panel pins of lpt_timing_top.
// Assumes an 8-cycle pixel and the short geometry H 4/1/1/1, V 1/2/2/2.
`timescale 1ns/1ps
module lpt_timing_props #(
	parameter int PIX_W = 16
) (
	// Clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// Panel pins and status
	input wire logic mode_active_out,
	input wire logic frame_sync_out,
	input wire logic line_sync_out,
	input wire logic bias_or_data_enable_out,
	input wire logic pixel_clock_out,
	input wire logic [PIX_W-1:0] pixel_data_bus,
	input wire logic frame_start_out
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!rst_n);

	a_fs_marks_start: assert property (
		frame_start_out |-> ##[0:1] frame_sync_out)
		else $error("frame sync missing at frame start");
	// One sync line is 7 pixels of 8 cycles
	a_vs_one_line: assert property (
		$rose(frame_sync_out) |-> ##55 frame_sync_out ##1 !frame_sync_out)
		else $error("frame sync width wrong");
	a_hs_one_pixel: assert property (
		$rose(line_sync_out) |=> line_sync_out[*7] ##1 !line_sync_out)
		else $error("line sync width wrong");
	a_pclk_half_period: assert property (
		$rose(pixel_clock_out) |=> pixel_clock_out[*3] ##1 !pixel_clock_out)
		else $error("pixel clock high time wrong");
	a_pclk_gated_blank: assert property (
		!mode_active_out && (line_sync_out || frame_sync_out)
		|-> !pixel_clock_out)
		else $error("passive pixel clock runs in blanking");
	a_blank_data_zero: assert property (
		mode_active_out && !bias_or_data_enable_out |-> pixel_data_bus == '0)
		else $error("data outside enable not zero");
	a_data_on_fall: assert property (
		mode_active_out && $changed(pixel_data_bus) |-> $fell(pixel_clock_out))
		else $error("data changed off the falling edge");
	a_bias_at_frame: assert property (
		!mode_active_out && $changed(bias_or_data_enable_out)
		|-> frame_start_out || $past(frame_start_out))
		else $error("bias changed inside a frame");
	// Mode may only move where no pixel or line sync is on the pins
	a_mode_at_frame: assert property (
		$changed(mode_active_out) |-> pixel_data_bus == '0 && !line_sync_out)
		else $error("mode changed inside a line");
endmodule : lpt_timing_props

bind lpt_timing_top lpt_timing_props #(.PIX_W(PIX_W)) u_props (
	.ref_clk, .rst_n, .mode_active_out, .frame_sync_out, .line_sync_out,
	.bias_or_data_enable_out, .pixel_clock_out, .pixel_data_bus,
	.frame_start_out);

// ===== tb/lpt_panel_model.sv
// Panel model: latches pixels on the rising pixel clock, counts lines.
// Assumes an active panel latches only with enable high.
`timescale 1ns/1ps
module lpt_panel_model (
	// Panel pins
	input wire logic active_panel,
	input wire logic frame_sync_out,
	input wire logic line_sync_out,
	input wire logic bias_or_data_enable_out,
	input wire logic pixel_clock_out,
	input wire logic [15:0] pixel_data_bus,
	// Observations
	output logic [15:0] cap_data,
	output int cap_cnt,
	output int lines_per_frame
);
	int lines = 0;
	initial cap_cnt = 0;
	initial lines_per_frame = 0;
	always @(posedge pixel_clock_out)
		if (!active_panel || bias_or_data_enable_out)
		begin
			cap_data <= pixel_data_bus;
			cap_cnt <= cap_cnt + 1;
		end
	always @(posedge line_sync_out)
		lines++;
	always @(posedge frame_sync_out)
	begin
		lines_per_frame <= lines;
		lines = 0;
	end
endmodule : lpt_panel_model

// ===== tb/test_lpt_timing_top.sv
// Bench for lpt_timing_top against a queue model and a panel model.
// Assumes the short geometry and an 80 ns pixel clock.
`timescale 1ns/1ps
module test_lpt_timing_top;
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic enable_in = 1'b0;
	logic active_matrix_mode = 1'b1;
	logic [15:0] pix_in_data = 16'h0000;
	logic pix_in_valid = 1'b0;
	logic pix_in_ready, frame_sync_out, line_sync_out;
	logic bias_or_data_enable_out, pixel_clock_out, mode_active_out;
	logic frame_start_out, underrun_out, feed = 1'b0, took = 1'b0;
	logic [15:0] pixel_data_bus, cap_data, exp_q[$];
	int cap_cnt, lines_per_frame, err_total = 0, n_compared = 0;
	int un_pend = 0, nfr = 0, prev_b = -1;
	always #5 ref_clk = ~ref_clk;

	// Pixel half period, V_SYNC, V_BP and V_FP stay at their defaults
	lpt_timing_top #(.H_ACTIVE(4), .H_FP(1), .H_SYNC(1), .H_BP(1),
		.V_ACTIVE(2)) u_dut (
		.ref_clk, .rst_n, .enable_in, .active_matrix_mode, .pix_in_data,
		.pix_in_valid, .pix_in_ready, .frame_sync_out, .line_sync_out,
		.bias_or_data_enable_out, .pixel_clock_out, .pixel_data_bus,
		.mode_active_out, .frame_start_out, .underrun_out);
	lpt_panel_model u_panel (.active_panel(mode_active_out),
		.frame_sync_out, .line_sync_out, .bias_or_data_enable_out,
		.pixel_clock_out, .pixel_data_bus, .cap_data, .cap_cnt,
		.lines_per_frame);

	task check(input string nm, input logic [31:0] seen, exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_total++;
			$display("[ERR] %s exp %h seen %h", nm, exp, seen);
		end
	endtask : check
	task complete_run;
		$display("errors %0d compared %0d", err_total, n_compared);
		if (err_total == 0 && n_compared > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : complete_run
	task wait_frames(input int n);
		for (int k = 0; k < 2000 && n > 0; k++)
		begin
			@(negedge ref_clk);
			if (frame_start_out === 1'b1)
				n--;
		end
		if (n > 0)
		begin
			check("frame_wait", 1, 0);
			complete_run;
		end
	endtask : wait_frames
	////////////////////////////////////////////////////////////////
	// Feeder holds a word until it is taken
	always @(posedge ref_clk)
	begin
		took <= rst_n && pix_in_valid && pix_in_ready;
		if (rst_n && pix_in_valid && pix_in_ready)
			exp_q.push_back(pix_in_data);
		if (rst_n && underrun_out === 1'b1)
			un_pend++;
	end
	always @(negedge ref_clk)
		if (took || !pix_in_valid)
		begin
			pix_in_valid <= feed && ($urandom % 4 != 0);
			pix_in_data <= 16'($urandom);
		end
	// An underrun pixel reaches the panel as zero
	always @(cap_cnt)
		if (un_pend > 0)
		begin
			un_pend--;
			check("pixel_zero", cap_data, 0);
		end
		else
			check("pixel", cap_data, exp_q.pop_front());
	always @(negedge frame_sync_out)
		if (rst_n)
		begin
			if (nfr > 0)
				check("lines", lines_per_frame, 7);
			if (mode_active_out === 1'b0 && prev_b >= 0)
				check("bias", bias_or_data_enable_out, !prev_b);
			prev_b = mode_active_out ? -1 : bias_or_data_enable_out;
			nfr++;
		end

	initial
	begin
		void'($urandom(32'h7412fcf3));
		repeat (10) @(negedge ref_clk);
		rst_n = 1'b1;
		feed = 1'b1;
		for (int k = 0; k < 300 && exp_q.size() < 32; k++)
			@(negedge ref_clk);
		repeat (4) @(negedge ref_clk);
		check("fill", exp_q.size(), 32);
		check("ready", pix_in_ready, 0);
		if (exp_q.size() != 32)
			complete_run;
		feed = 1'b0;
		enable_in = 1'b1;
		for (int k = 0; k < 4000 && underrun_out !== 1'b1; k++)
			@(negedge ref_clk);
		check("underrun", underrun_out, 1);
		if (underrun_out !== 1'b1)
			complete_run;
		feed = 1'b1;
		wait_frames(3);
		active_matrix_mode = 1'b0;
		wait_frames(4);
		check("mode", mode_active_out, 0);
		active_matrix_mode = 1'b1;
		wait_frames(2);
		check("mode", mode_active_out, 1);
		rst_n = 1'b0;
		@(negedge ref_clk);
		check("pins", {frame_sync_out, line_sync_out, pixel_clock_out,
			bias_or_data_enable_out, pixel_data_bus}, 0);
		check("ready_rst", pix_in_ready, 1);
		complete_run;
	end
endmodule : test_lpt_timing_top
